// ==== rtl/ddl_host.sv ====
// apb-controlled host that drives the dual converter parallel port
// Operation
// - data held stable around rising strobe
// - select low around each strobe
// - synchronous mode pulses load low after the last strobe
// - byte select set before strobe
// - channel select picks first or second
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ddl_params.svh"
module ddl_host #(
    parameter int DATA_W = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] parallel_data_pins,
    output logic             chip_select_n,
    output logic             write_n,
    output logic             channel_select,
    output logic             upper_byte_select,
    output logic             load_output_n,
    output logic             clear_n,
    output logic             power_down_n
);
    ddl_strobe_if tif ();

    ddl_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tif)
    );

    ddl_pkg::ddl_state_e st_q, st_d;
    logic [31:0] cmd_q, cmd_d;
    logic        phase_q, phase_d;
    logic        pwr_q, pwr_d;
    logic        sync_q, sync_d;
    logic        done_q, done_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [15:0] db_q, db_d;
    logic        cs_q, cs_d, wr_q, wr_d, a_q, a_d, hb_q, hb_d;
    logic        ld_q, ld_d, clr_q, clr_d;
    logic        acc;

    assign acc = psel && penable && !pready_q;

    // apb slave, command launch and pin sequencer
    always_comb begin
        st_d = st_q; cmd_d = cmd_q; phase_d = phase_q;
        pwr_d = pwr_q; sync_d = sync_q; done_d = done_q;
        prdata_d = 32'h0000_0000; pready_d = 1'b0; pslverr_d = 1'b0;
        db_d = db_q; cs_d = cs_q; wr_d = wr_q; a_d = a_q; hb_d = hb_q;
        ld_d = ld_q; clr_d = clr_q;
        tif.start = 1'b0; tif.cycles = 8'h00;
        if (acc) begin
            pready_d = 1'b1;
            if (paddr == `DDL_REG_CMD) begin
                if (pwrite && st_q == ddl_pkg::DDL_IDLE) begin
                    cmd_d = pwdata; phase_d = 1'b0; done_d = 1'b0;
                    if (pwdata[`DDL_CMD_CLEAR_BIT]) begin
                        st_d = ddl_pkg::DDL_CLR; clr_d = 1'b0;
                        tif.start = 1'b1; tif.cycles = 8'(`DDL_PULSE_CYC);
                    end else if (pwdata[`DDL_CMD_LOAD_BIT]) begin
                        st_d = ddl_pkg::DDL_LOAD; ld_d = 1'b0;
                        tif.start = 1'b1; tif.cycles = 8'(`DDL_PULSE_CYC);
                    end else begin
                        st_d = ddl_pkg::DDL_SETUP;
                    end
                end else if (pwrite) begin
                    pslverr_d = 1'b1; // busy: command refused
                end else begin
                    prdata_d = cmd_q;
                end
            end else if (paddr == `DDL_REG_CTRL) begin
                if (pwrite) begin
                    pwr_d = pwdata[`DDL_CTRL_PWR_BIT];
                    sync_d = pwdata[`DDL_CTRL_SYNC_BIT];
                end
                prdata_d = {30'h0, sync_q, pwr_q};
            end else if (paddr == `DDL_REG_STATUS) begin
                prdata_d = {30'h0, done_q, st_q != ddl_pkg::DDL_IDLE};
            end else begin
                pslverr_d = 1'b1;
            end
        end
        case (st_q)
            // idle keeps the launch decided by the bus decode above
            ddl_pkg::DDL_IDLE: begin
            end
            ddl_pkg::DDL_SETUP: begin
                // place address, byte select and data before the strobe
                cs_d = 1'b0;
                a_d = cmd_q[`DDL_CMD_CHAN_BIT];
                if (cmd_q[`DDL_CMD_WIDE_BIT]) begin
                    hb_d = 1'b0;
                    db_d = {2'b00, cmd_q[`DDL_CMD_REFBUF_BIT], cmd_q[`DDL_CMD_GAIN_BIT],
                            cmd_q[11:0]};
                end else if (!phase_q) begin
                    hb_d = 1'b0;
                    db_d = {8'h00, cmd_q[7:0]};
                end else begin
                    hb_d = 1'b1;
                    db_d = {8'h00, cmd_q[`DDL_CMD_GAIN_BIT], cmd_q[`DDL_CMD_REFBUF_BIT],
                            2'b00, cmd_q[11:8]};
                end
                tif.start = 1'b1; tif.cycles = 8'(`DDL_SETUP_CYC);
                st_d = ddl_pkg::DDL_PULSE;
            end
            ddl_pkg::DDL_PULSE: begin
                if (!tif.busy && wr_q) begin
                    wr_d = 1'b0;
                    tif.start = 1'b1; tif.cycles = 8'(`DDL_PULSE_CYC);
                end else if (!tif.busy && !wr_q) begin
                    wr_d = 1'b1;
                    tif.start = 1'b1; tif.cycles = 8'(`DDL_HOLD_CYC);
                    st_d = ddl_pkg::DDL_HOLD;
                end
            end
            ddl_pkg::DDL_HOLD: begin
                if (!tif.busy) begin
                    cs_d = 1'b1;
                    if (!cmd_q[`DDL_CMD_WIDE_BIT] && !phase_q) begin
                        phase_d = 1'b1; st_d = ddl_pkg::DDL_SETUP;
                    end else if (sync_q) begin
                        st_d = ddl_pkg::DDL_LOAD; ld_d = 1'b0;
                        tif.start = 1'b1; tif.cycles = 8'(`DDL_PULSE_CYC);
                    end else begin
                        st_d = ddl_pkg::DDL_IDLE; done_d = 1'b1;
                    end
                end
            end
            ddl_pkg::DDL_LOAD: begin
                if (!tif.busy) begin
                    ld_d = 1'b1; st_d = ddl_pkg::DDL_IDLE; done_d = 1'b1;
                end
            end
            ddl_pkg::DDL_CLR: begin
                if (!tif.busy) begin
                    clr_d = 1'b1; st_d = ddl_pkg::DDL_IDLE; done_d = 1'b1;
                end
            end
            default: st_d = ddl_pkg::DDL_IDLE;
        endcase
    end

    // register everything; pins idle inactive after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ddl_pkg::DDL_IDLE; cmd_q <= 32'h0000_0000; phase_q <= 1'b0;
            pwr_q <= 1'b1; sync_q <= 1'b0; done_q <= 1'b0;
            prdata_q <= 32'h0000_0000; pready_q <= 1'b0; pslverr_q <= 1'b0;
            db_q <= 16'h0000; cs_q <= 1'b1; wr_q <= 1'b1; a_q <= 1'b0; hb_q <= 1'b0;
            ld_q <= 1'b1; clr_q <= 1'b1;
        end else begin
            st_q <= st_d; cmd_q <= cmd_d; phase_q <= phase_d;
            pwr_q <= pwr_d; sync_q <= sync_d; done_q <= done_d;
            prdata_q <= prdata_d; pready_q <= pready_d; pslverr_q <= pslverr_d;
            db_q <= db_d; cs_q <= cs_d; wr_q <= wr_d; a_q <= a_d; hb_q <= hb_d;
            ld_q <= ld_d; clr_q <= clr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign parallel_data_pins = db_q;
    assign chip_select_n = cs_q;
    assign write_n = wr_q;
    assign channel_select = a_q;
    assign upper_byte_select = hb_q;
    assign load_output_n = ld_q;
    assign clear_n = clr_q;
    assign power_down_n = pwr_q;

    sequence strobe_rise_s;
        !wr_q ##1 wr_q;
    endsequence

    strobe_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_q |-> !cs_q) else $error("strobe low without select");
    data_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
        strobe_rise_s |-> $stable(db_q) && $stable(a_q) && $stable(hb_q))
        else $error("data moved at strobe rise");
    load_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == ddl_pkg::DDL_PULSE && !sync_q) |-> ld_q)
        else $error("load active during async write");
    clr_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(clr_q) |-> !clr_q ##1 clr_q) else $error("clear pulse wrong length");
    load_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ld_q) |-> ##1 ld_q) else $error("load pulse wrong length");
    upper_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_q && hb_q) |-> db_q[5:4] == 2'b00) else $error("upper byte lines wrong");
    pready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q |=> !pready_q) else $error("pready held");
endmodule

// ==== inc/ddl_params.svh ====
// timing counts, field positions and register offsets for the dual converter host
`ifndef DDL_PARAMS_SVH
`define DDL_PARAMS_SVH
`define DDL_CLK_NS        100
`define DDL_T_SETUP_NS    30
`define DDL_T_PULSE_NS    30
`define DDL_T_HOLD_NS     10
`define DDL_SETUP_CYC     ((`DDL_T_SETUP_NS + `DDL_CLK_NS - 1) / `DDL_CLK_NS)
`define DDL_PULSE_CYC     ((`DDL_T_PULSE_NS + `DDL_CLK_NS - 1) / `DDL_CLK_NS)
`define DDL_HOLD_CYC      ((`DDL_T_HOLD_NS + `DDL_CLK_NS - 1) / `DDL_CLK_NS)
`define DDL_REG_CMD       12'h000
`define DDL_REG_CTRL      12'h004
`define DDL_REG_STATUS    12'h008
`define DDL_CMD_DATA_LSB  0
`define DDL_CMD_DATA_W    12
`define DDL_CMD_CHAN_BIT  12
`define DDL_CMD_UPPER_BIT 13
`define DDL_CMD_REFBUF_BIT 14
`define DDL_CMD_GAIN_BIT  15
`define DDL_CMD_LOAD_BIT  16
`define DDL_CMD_CLEAR_BIT 17
`define DDL_CMD_WIDE_BIT  18
`define DDL_CTRL_PWR_BIT  0
`define DDL_CTRL_SYNC_BIT 1
`define DDL_STAT_BUSY_BIT 0
`define DDL_STAT_DONE_BIT 1
`define DDL_UPPER_REF_BIT 6
`define DDL_UPPER_GAIN_BIT 7
`endif

// ==== inc/ddl_pkg.sv ====
// types shared by the dual converter host
package ddl_pkg;
    typedef enum logic [2:0] {
        DDL_IDLE  = 3'b000,
        DDL_SETUP = 3'b001,
        DDL_PULSE = 3'b010,
        DDL_HOLD  = 3'b011,
        DDL_LOAD  = 3'b100,
        DDL_CLR   = 3'b101
    } ddl_state_e;
    typedef logic [15:0] ddl_word_t;
endpackage

// ==== inc/ddl_strobe_if.sv ====
// strobe request between sequencer and pin timer
`timescale 1ns/1ps
interface ddl_strobe_if;
    logic       start;
    logic [7:0] cycles;
    logic       busy;
    modport seq (output start, output cycles, input busy);
    modport tmr (input start, input cycles, output busy);
endinterface

// ==== rtl/ddl_timer.sv ====
// small down counter that times each pin phase
`timescale 1ns/1ps
module ddl_timer (
    input  wire logic   pclk,
    input  wire logic   presetn,
    ddl_strobe_if.tmr   tif
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // load on start, count down while nonzero
    always_comb begin
        cnt_d = cnt_q;
        if (tif.start) begin
            cnt_d = tif.cycles;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // busy from the register only: the sequencer reads busy and raises start
    // in one process, so a start term here would form a zero-delay loop
    assign tif.busy = (cnt_q > 8'h01);
endmodule

// ==== verification/ddl_dev_model.sv ====
// behavioural model of the dual converter logic, byte-loading variant
`timescale 1ns/1ps
module ddl_dev_model (
    input  wire logic        chip_select_n,
    input  wire logic        write_n,
    input  wire logic        channel_select,
    input  wire logic        upper_byte_select,
    input  wire logic        load_output_n,
    input  wire logic        clear_n,
    input  wire logic [15:0] parallel_data_pins,
    output logic      [13:0] conv_a,
    output logic      [13:0] conv_b
);
    // per channel: scale 13, drive 12, code 11:0
    logic [13:0] ins [2];
    logic [13:0] cv  [2];
    logic [1:0]  chg;
    assign conv_a = cv[0];
    assign conv_b = cv[1];
    // unchanged channels stay put, which spares them crosstalk
    task automatic xfer();
        for (int k = 0; k < 2; k++) begin
            if (chg[k]) begin
                cv[k] = ins[k];
            end
        end
        chg = 2'b00;
    endtask
    // power-up and clear zero both stages; power-down keeps them
    task automatic zero();
        ins = '{default: 14'h0000};
        cv  = '{default: 14'h0000};
        chg = 2'b00;
    endtask
    initial zero();
    always @(negedge clear_n) zero();
    // capture on the rising strobe while selected
    always @(posedge write_n) begin
        if (clear_n && !chip_select_n) begin
            if (upper_byte_select) begin
                ins[channel_select][13:8] = {parallel_data_pins[7:6],
                                             parallel_data_pins[3:0]};
            end else begin
                ins[channel_select][7:0] = parallel_data_pins[7:0];
            end
            chg[channel_select] = 1'b1;
            if (!load_output_n) xfer();
        end
    end
    always @(negedge load_output_n) if (clear_n) xfer();
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the apb dual converter host
`timescale 1ns/1ps
`include "ddl_params.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] pins;
    logic        cs_n, wr_n, chan, upper, load_n, clr_n, pwr_n;
    logic [13:0] cva, cvb;
    int          n_mismatch, n_compared;
    logic [15:0] lat_pins;
    logic        lat_upper;
    int          n_strobe;
    // latch what stands on the pins at each selected strobe rise
    always @(posedge wr_n) begin
        if (cs_n === 1'b0) begin
            lat_pins = pins;
            lat_upper = upper;
            n_strobe++;
        end
    end
    ddl_host ddl_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .parallel_data_pins(pins), .chip_select_n(cs_n), .write_n(wr_n),
        .channel_select(chan), .upper_byte_select(upper), .load_output_n(load_n),
        .clear_n(clr_n), .power_down_n(pwr_n));
    ddl_dev_model ddl_dev_model_inst (.chip_select_n(cs_n), .write_n(wr_n),
        .channel_select(chan), .upper_byte_select(upper), .load_output_n(load_n),
        .clear_n(clr_n), .parallel_data_pins(pins), .conv_a(cva), .conv_b(cvb));
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic x);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, x});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    // poll until done and not busy; pin sequence length is not fixed
    task automatic done();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, `DDL_REG_STATUS, 32'h0, r, e);
            if (r[1:0] === 2'b10) return;
        end
        n_mismatch++;
        results();
    endtask
    task automatic cv(input logic [13:0] a, input logic [13:0] b);
        chk({18'h0, cva}, {18'h0, a});
        chk({18'h0, cvb}, {18'h0, b});
    endtask
    function automatic logic [31:0] cmd(input logic c, input logic [11:0] v,
                                        input logic rf, input logic gn);
        return {16'h0000, gn, rf, 1'b0, c, v};
    endfunction
    task automatic t_reset();
        rd(`DDL_REG_CTRL, 32'h1, 1'b0);
        chk({31'h0, pwr_n}, 32'h1);
        cv(14'h0000, 14'h0000);
    endtask
    task automatic t_async();
        wr(`DDL_REG_CTRL, 32'h1, 1'b0);
        wr(`DDL_REG_CMD, cmd(1'b0, 12'habc, 1'b1, 1'b0), 1'b0);
        done();
        wr(`DDL_REG_CMD, cmd(1'b1, 12'h5f3, 1'b0, 1'b1), 1'b0);
        done();
        cv(14'h0000, 14'h0000);
        wr(`DDL_REG_CMD, 32'h0001_0000, 1'b0);
        done();
        cv(14'h1abc, 14'h25f3);
    endtask
    task automatic t_sync();
        wr(`DDL_REG_CTRL, 32'h3, 1'b0);
        wr(`DDL_REG_CMD, cmd(1'b1, 12'hfff, 1'b1, 1'b1), 1'b0);
        done();
        cv(14'h1abc, 14'h3fff);
    endtask
    task automatic t_clear();
        wr(`DDL_REG_CMD, 32'h0002_0000, 1'b0);
        done();
        cv(14'h0000, 14'h0000);
    endtask
    // unmapped read, then a command refused while the pins are busy
    task automatic t_errs();
        rd(12'h00c, 32'h0, 1'b1);
        wr(`DDL_REG_CMD, cmd(1'b0, 12'h001, 1'b0, 1'b0), 1'b0);
        wr(`DDL_REG_CMD, cmd(1'b1, 12'h800, 1'b0, 1'b0), 1'b1);
        done();
        cv(14'h0001, 14'h0000);
    endtask
    task automatic t_pwr();
        wr(`DDL_REG_CTRL, 32'h0, 1'b0);
        rd(`DDL_REG_CTRL, 32'h0, 1'b0);
        chk({31'h0, pwr_n}, 32'h0);
        cv(14'h0001, 14'h0000);
        wr(`DDL_REG_CTRL, 32'h1, 1'b0);
    endtask
    // word-mode write: one strobe carrying the whole code and both controls
    task automatic t_word();
        n_strobe = 0;
        wr(`DDL_REG_CMD, cmd(1'b1, 12'h9c5, 1'b1, 1'b0) | 32'h0004_0000, 1'b0);
        done();
        chk(n_strobe, 32'h1);
        chk({16'h0, lat_pins}, 32'h0000_29c5);
        chk({31'h0, lat_upper}, 32'h0);
        cv(14'h0001, 14'h0000);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_async();
        t_sync();
        t_clear();
        t_errs();
        t_pwr();
        t_word();
        results();
    end
endmodule
